// [common/ext_bus_pkg.sv]
// Types of the external memory bus interface
package ext_bus_pkg;

   // ----------------------------------------
   // Machine cycle states, bus cycle kinds and flow op codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      ph_s1 = 5'h01,
      ph_s2 = 5'h02,
      ph_s3 = 5'h04,
      ph_s4 = 5'h08,
      ph_s5 = 5'h10
   } phase_type;

   typedef enum logic [4:0] {
      cy_idle = 5'h01,
      cy_fetch_int = 5'h02,
      cy_fetch_ext = 5'h04,
      cy_data_rd = 5'h08,
      cy_data_wr = 5'h10
   } cycle_type;

   typedef enum logic [2:0] {
      jump_op = 3'h0,
      call_op = 3'h1,
      return_op = 3'h2,
      return_restore_op = 3'h3,
      select_low_bank_op = 3'h4,
      select_high_bank_op = 3'h5,
      interrupt_op = 3'h6
   } op_code_type;

   // ----------------------------------------
   // Carriers
   // ----------------------------------------
   typedef struct packed {
      logic valid;
      op_code_type code;
      logic [10:0] target;
      logic vec_high;
   } flow_op_type;

   typedef struct packed {
      logic req;
      logic write;
      logic ptr_sel;
      logic [7:0] pointer_reg_zero;
      logic [7:0] pointer_reg_one;
      logic [7:0] wdata;
   } data_req_type;

   typedef struct packed {
      logic [7:0] data_out;
      logic data_oe_n;
      logic [3:0] port2_low;
      logic ale;
      logic program_store_strobe_n;
      logic rd_n;
      logic wr_n;
   } bus_pins_type;

endpackage

// [common/ext_bus_regs.svh]
// Constants of the external memory bus interface
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH

// ----------------------------------------
// Address map
// ----------------------------------------
`define INT_ROM_LIMIT 12'h400
`define VEC_LOW 11'h003
`define VEC_HIGH 11'h007
`define STACK_DEPTH 8

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_NS 10
`define STATE_TIME_NS 100
`define STATE_DIV (`STATE_TIME_NS / `CLK_PERIOD_NS)
`define BOOT_WAIT 2'h3

`endif

// [tb/ext_mem_model.sv]
// Behavioural external program and data memories behind an address latch
`timescale 1ns/1ps

module ext_mem_model
   import ext_bus_pkg::*;
(
   // Clock
   input wire logic mclk,
   // Device pins and resolved bus level
   input wire bus_pins_type pins,
   input wire logic [7:0] bus_level,
   input wire logic slow,
   // Drive back onto the bus
   output logic drv_en,
   output logic [7:0] drv_data,
   output logic [11:0] lat_addr
);
   logic [7:0] dmem [0:255];
   logic [7:0] lat_lo;
   logic [3:0] lat_hi;
   int low_cnt = 0;
   logic strobe;

   assign strobe = !pins.program_store_strobe_n || !pins.rd_n;
   assign lat_addr = {lat_hi, lat_lo};

   // --------------------------------
   // Address latch
   // --------------------------------
   // Last value seen while the latch strobe is high is what the trailing edge holds
   always @(posedge mclk) begin
      if (pins.ale === 1'b1) lat_lo <= bus_level;
      if (pins.program_store_strobe_n === 1'b0) lat_hi <= pins.port2_low;
   end

   // --------------------------------
   // Read side
   // --------------------------------
   always @(posedge mclk) low_cnt <= strobe ? low_cnt + 1 : 0;
   // A slow part leaves the bus floating for the first cycles of the strobe
   assign drv_en = strobe && (low_cnt >= (slow ? 3 : 0));
   assign drv_data = !pins.program_store_strobe_n ? (lat_addr[7:0] ^ {lat_addr[11:8], 4'h6}) : dmem[lat_lo];

   // --------------------------------
   // Write side
   // --------------------------------
   always @(posedge pins.wr_n) dmem[lat_lo] <= bus_level;
endmodule

// [tb/tb.sv]
// Self-checking testbench of the external memory bus interface
`timescale 1ns/1ps
`include "ext_bus_regs.svh"

module tb
   import ext_bus_pkg::*;
;
   logic mclk, rst_n, external_access_input, rom_read_enable, single_step_n;
   logic fetch_req, instr_end, instr_valid, data_done, halted, read_mode;
   logic slow, exp_int, ro_drive, ale_q, drv_en;
   logic [7:0] bus_level, last_bus, bus_port_val, instr, read_data, rom_data, drv_data;
   logic [3:0] port2_val;
   logic [11:0] rom_addr, lat_addr, ro_addr, pc;
   logic bank, isr;
   logic [11:0] stk [$];
   logic [7:0] dm [0:255];
   flow_op_type flow_op;
   data_req_type data_req;
   bus_pins_type pins;
   int errors = 0;
   int n_tests = 0;

   function automatic logic [7:0] pm(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], 4'h6};
   endfunction

   function automatic logic [7:0] rm(input logic [11:0] a);
      return a[7:0] + 8'h3C;
   endfunction

   // A floating bus shows the inverse of its last level, never a settled value
   assign bus_level = (pins.data_oe_n === 1'b0) ? pins.data_out : drv_en ? drv_data :
                      ro_drive ? ro_addr[7:0] : ~last_bus;
   assign rom_data = rm(rom_addr);

   ext_memory_bus #(.STATE_DIV(4), .STACK_DEPTH(8)) dut (
      .mclk(mclk), .rst_n(rst_n), .bus_in(bus_level), .port2_low_in(ro_addr[11:8]),
      .external_access_input(external_access_input), .rom_read_enable(rom_read_enable),
      .single_step_n(single_step_n), .pins(pins), .fetch_req(fetch_req), .instr_end(instr_end),
      .flow_op(flow_op), .data_req(data_req), .bus_port_val(bus_port_val), .port2_val(port2_val),
      .instr(instr), .instr_valid(instr_valid), .read_data(read_data), .data_done(data_done),
      .halted(halted), .read_mode(read_mode), .rom_addr(rom_addr), .rom_data(rom_data)
   );

   ext_mem_model mem_model (
      .mclk(mclk), .pins(pins), .bus_level(bus_level), .slow(slow),
      .drv_en(drv_en), .drv_data(drv_data), .lat_addr(lat_addr)
   );

   // --------------------------------
   // Reporting
   // --------------------------------
   task automatic final_report();
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   // --------------------------------
   // Drivers
   // --------------------------------
   task automatic step();
      @(posedge mclk);
      #1;
   endtask

   task automatic wait_for(input int kind);
      int n;
      logic hit;
      for (n = 0; n < 400; n++) begin
         step();
         case (kind)
            0: hit = instr_valid === 1'b1;
            1: hit = data_done === 1'b1;
            2: hit = halted === 1'b1;
            3: hit = halted === 1'b0;
            4: hit = read_mode === 1'b1;
            5: hit = pins.ale === 1'b1;
            default: hit = pins.ale === 1'b0;
         endcase
         if (hit) return;
      end
      errors++;
      $display("[FAIL] wait kind %0d expected 1 seen 0", kind);
      final_report();
   endtask

   task automatic do_reset(input logic ea, input logic ro);
      rst_n = 1'b0;
      external_access_input = ea;
      rom_read_enable = ro;
      ro_drive = ro;
      fetch_req = 1'b0;
      data_req.req = 1'b0;
      repeat (3) step();
      rst_n = 1'b1;
      pc = 12'h000;
      bank = 1'b0;
      isr = 1'b0;
      stk.delete();
      repeat (6) step();
   endtask

   task automatic fetch();
      logic [11:0] a;
      logic ext;
      step();
      a = pc;
      ext = external_access_input || (a >= `INT_ROM_LIMIT);
      slow = 1'($urandom);
      exp_int = !ext;
      fetch_req = 1'b1;
      wait_for(0);
      fetch_req = 1'b0;
      exp_int = 1'b0;
      pc = {pc[11], pc[10:0] + 11'h001};
      chk("instr", {4'h0, ext ? pm(a) : rm(a)}, {4'h0, instr});
      if (ext) chk("fetch address", a, lat_addr);
   endtask

   task automatic flow(input op_code_type code, input logic [10:0] t, input logic vh);
      step();
      flow_op = '{valid: 1'b1, code: code, target: t, vec_high: vh};
      step();
      flow_op.valid = 1'b0;
      case (code)
         jump_op: pc = {bank & !isr, t};
         call_op: begin
            stk.push_back(pc);
            pc = {bank & !isr, t};
         end
         return_op: pc = stk.pop_back();
         return_restore_op: begin
            pc = stk.pop_back();
            isr = 1'b0;
         end
         select_low_bank_op: bank = 1'b0;
         select_high_bank_op: bank = 1'b1;
         default: begin
            stk.push_back(pc);
            pc = {1'b0, vh ? `VEC_HIGH : `VEC_LOW};
            isr = 1'b1;
         end
      endcase
   endtask

   task automatic dacc(input logic wr, input logic sel, input logic [7:0] a, input logic [7:0] d);
      step();
      slow = 1'($urandom);
      data_req = '{req: 1'b1, write: wr, ptr_sel: sel, pointer_reg_zero: (sel ? ~a : a),
                   pointer_reg_one: (sel ? a : ~a), wdata: d};
      wait_for(1);
      data_req.req = 1'b0;
      chk("data address", {4'h0, a}, {4'h0, lat_addr[7:0]});
      if (wr) dm[a] = d;
      else chk("read data", {4'h0, dm[a]}, {4'h0, read_data});
   endtask

   // --------------------------------
   // Pin monitor
   // --------------------------------
   always @(posedge mclk) begin
      last_bus <= bus_level;
      ale_q <= pins.ale;
      if (rst_n && pins.ale === 1'b1 && ale_q === 1'b0) begin
         chk("port2 at ale rise", {8'h00, port2_val}, {8'h00, pins.port2_low});
         if (halted === 1'b1 && single_step_n === 1'b0) chk("bus at ale rise", {4'h0, bus_port_val}, {4'h0, pins.data_out});
      end
      if (exp_int && (pins.program_store_strobe_n !== 1'b1 || pins.data_oe_n !== 1'b1)) chk("quiet bus", 12'h001, 12'h000);
   end

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   initial begin
      #900000;
      errors++;
      final_report();
   end

   // --------------------------------
   // Main sequence
   // --------------------------------
   initial begin
      void'($urandom(32'hCD09307F));
      rst_n = 1'b0;
      single_step_n = 1'b1;
      instr_end = 1'b0;
      slow = 1'b0;
      exp_int = 1'b0;
      ro_addr = 12'h000;
      last_bus = 8'h00;
      flow_op = '0;
      data_req = '0;
      bus_port_val = 8'($urandom);
      port2_val = 4'($urandom);
      do_reset(1'b0, 1'b0);
      flow(jump_op, 11'h3FD, 1'b0);
      repeat (4) fetch();
      flow(select_high_bank_op, 11'h000, 1'b0);
      fetch();
      flow(jump_op, 11'h123, 1'b0);
      fetch();
      flow(call_op, 11'h055, 1'b0);
      fetch();
      flow(select_low_bank_op, 11'h000, 1'b0);
      flow(return_op, 11'h000, 1'b0);
      fetch();
      flow(jump_op, 11'h200, 1'b0);
      fetch();
      flow(select_high_bank_op, 11'h000, 1'b0);
      flow(jump_op, 11'h010, 1'b0);
      flow(interrupt_op, 11'h000, 1'b1);
      fetch();
      flow(select_low_bank_op, 11'h000, 1'b0);
      flow(jump_op, 11'h050, 1'b0);
      fetch();
      flow(return_restore_op, 11'h000, 1'b0);
      fetch();
      flow(interrupt_op, 11'h000, 1'b0);
      fetch();
      flow(return_restore_op, 11'h000, 1'b0);
      flow(jump_op, 11'h411, 1'b0);
      for (int i = 0; i < 6; i++) begin
         ro_addr[7:0] = 8'($urandom);
         dacc(1'b1, i[1], ro_addr[7:0], 8'($urandom));
         dacc(1'b0, !i[1], ro_addr[7:0], 8'h00);
      end
      single_step_n = 1'b0;
      fetch();
      instr_end = 1'b1;
      step();
      instr_end = 1'b0;
      wait_for(2);
      wait_for(5);
      wait_for(6);
      repeat (2) step();
      chk("step bus", {4'h0, pc[7:0]}, {4'h0, pins.data_out});
      chk("step port2", {8'h00, pc[11:8]}, {8'h00, pins.port2_low});
      single_step_n = 1'b1;
      wait_for(3);
      fetch();
      do_reset(1'b1, 1'b0);
      fetch();
      fetch();
      ro_addr = 12'($urandom);
      do_reset(1'b0, 1'b1);
      wait_for(4);
      repeat (3) step();
      chk("readout address", ro_addr, rom_addr);
      chk("readout word", {4'h0, rm(ro_addr)}, {4'h0, pins.data_out});
      final_report();
   end
endmodule

// [verilog/ext_memory_bus.sv]
// External memory bus interface: fetch, bank switch, data moves, single step, read-out
`timescale 1ns/1ps
`include "ext_bus_regs.svh"

module ext_memory_bus
   import ext_bus_pkg::*;
#(
   parameter int STATE_DIV = `STATE_DIV,
   parameter int STACK_DEPTH = `STACK_DEPTH
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Pins from outside
   input wire logic [7:0] bus_in,
   input wire logic [3:0] port2_low_in,
   input wire logic external_access_input,
   input wire logic rom_read_enable,
   input wire logic single_step_n,
   // Pins to outside
   output bus_pins_type pins,
   // Core requests
   input wire logic fetch_req,
   input wire logic instr_end,
   input wire flow_op_type flow_op,
   input wire data_req_type data_req,
   input wire logic [7:0] bus_port_val,
   input wire logic [3:0] port2_val,
   // Core answers
   output logic [7:0] instr,
   output logic instr_valid,
   output logic [7:0] read_data,
   output logic data_done,
   output logic halted,
   output logic read_mode,
   // Internal program memory
   output logic [11:0] rom_addr,
   input wire logic [7:0] rom_data
);

   localparam int SPW = $clog2(STACK_DEPTH);

   function automatic logic [11:0] pc_next_seq(input logic [11:0] p);
      pc_next_seq = {p[11], p[10:0] + 11'h001};
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [7:0] bus_s1_q, bus_s2_q;
   logic [3:0] p2_s1_q, p2_s2_q;
   logic xacc_s1_q, xacc_s2_q, rre_s1_q, rre_s2_q, ss_s1_q, ss_s2_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bus_s1_q <= 8'h00;
         bus_s2_q <= 8'h00;
         p2_s1_q <= 4'h0;
         p2_s2_q <= 4'h0;
         {xacc_s1_q, xacc_s2_q, rre_s1_q, rre_s2_q} <= 4'h0;
         {ss_s1_q, ss_s2_q} <= 2'h3;
      end else begin
         bus_s1_q <= bus_in;
         bus_s2_q <= bus_s1_q;
         p2_s1_q <= port2_low_in;
         p2_s2_q <= p2_s1_q;
         xacc_s1_q <= external_access_input;
         xacc_s2_q <= xacc_s1_q;
         rre_s1_q <= rom_read_enable;
         rre_s2_q <= rre_s1_q;
         ss_s1_q <= single_step_n;
         ss_s2_q <= ss_s1_q;
      end
   end

   // ----------------------------------------
   // Mode capture after reset release
   // ----------------------------------------
   logic [1:0] boot_cnt_q;
   logic booted_q, ext_mode_q, read_mode_q;
   logic [11:0] rd_addr_q;

   // External access and read-out are sampled once, so changes outside reset are ignored
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         boot_cnt_q <= 2'h0;
         booted_q <= 1'b0;
         ext_mode_q <= 1'b0;
         read_mode_q <= 1'b0;
         rd_addr_q <= 12'h000;
      end else if (!booted_q) begin
         boot_cnt_q <= boot_cnt_q + 2'h1;
         if (boot_cnt_q == `BOOT_WAIT) begin
            booted_q <= 1'b1;
            ext_mode_q <= xacc_s2_q;
            read_mode_q <= rre_s2_q;
            rd_addr_q <= {p2_s2_q, bus_s2_q};
         end
      end
   end

   // ----------------------------------------
   // Machine cycle timing
   // ----------------------------------------
   logic tick;
   phase_type phase;

   machine_state_timer #(.STATE_DIV(STATE_DIV)) u_timer (
      .mclk(mclk),
      .rst_n(rst_n),
      .tick(tick),
      .phase(phase)
   );

   // ----------------------------------------
   // Cycle selection
   // ----------------------------------------
   logic [11:0] pc_q, fa_q;
   logic [7:0] da_q, wd_q;
   logic bank_ff_q, in_isr_q, halted_q;
   cycle_type cycle_q;

   wire s1 = phase == ph_s1;
   wire strobe_ph = phase == ph_s3 || phase == ph_s4;
   wire program_store_strobe_n_ph = phase == ph_s2 || strobe_ph;
   wire cyc_start = tick && s1 && booted_q && !read_mode_q;
   wire cyc_end = tick && phase == ph_s5;
   wire ext_fetch = ext_mode_q || pc_q >= `INT_ROM_LIMIT;
   wire [7:0] ptr_addr = data_req.ptr_sel ? data_req.pointer_reg_one : data_req.pointer_reg_zero;
   wire cycle_type cycle_sel = halted_q ? cy_idle :
                               data_req.req ? (data_req.write ? cy_data_wr : cy_data_rd) :
                               fetch_req ? (ext_fetch ? cy_fetch_ext : cy_fetch_int) : cy_idle;
   wire cycle_type cur_cycle = cyc_start ? cycle_sel : cycle_q;
   wire [11:0] cur_faddr = cyc_start ? pc_q : fa_q;
   wire [7:0] cur_daddr = cyc_start ? ptr_addr : da_q;
   wire fetch_start = cyc_start && (cycle_sel == cy_fetch_int || cycle_sel == cy_fetch_ext);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cycle_q <= cy_idle;
         fa_q <= 12'h000;
         da_q <= 8'h00;
         wd_q <= 8'h00;
      end else if (cyc_start) begin
         cycle_q <= cycle_sel;
         fa_q <= pc_q;
         da_q <= ptr_addr;
         wd_q <= data_req.wdata;
      end
   end

   // ----------------------------------------
   // Program counter, bank and stack
   // ----------------------------------------
   logic [11:0] stack_q [STACK_DEPTH];
   logic [SPW-1:0] sp_q;

   wire op_branch = flow_op.valid && (flow_op.code == jump_op || flow_op.code == call_op);
   wire op_return = flow_op.valid && (flow_op.code == return_op || flow_op.code == return_restore_op);
   wire op_intr = flow_op.valid && flow_op.code == interrupt_op;
   wire op_push = flow_op.valid && (flow_op.code == call_op || flow_op.code == interrupt_op);
   wire bank_src = in_isr_q ? 1'b0 : bank_ff_q;
   wire [SPW-1:0] sp_dec = sp_q - SPW'(1);
   wire [10:0] vec = flow_op.vec_high ? `VEC_HIGH : `VEC_LOW;
   wire [11:0] pc_d = op_branch ? {bank_src, flow_op.target} :
                      op_return ? stack_q[sp_dec] :
                      op_intr ? {1'b0, vec} :
                      fetch_start ? pc_next_seq(pc_q) : pc_q;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pc_q <= 12'h000;
         sp_q <= '0;
         bank_ff_q <= 1'b0;
         in_isr_q <= 1'b0;
      end else begin
         pc_q <= pc_d;
         if (op_push) begin
            sp_q <= sp_q + SPW'(1);
         end else if (op_return) begin
            sp_q <= sp_dec;
         end
         if (flow_op.valid && flow_op.code == select_high_bank_op) begin
            bank_ff_q <= 1'b1;
         end else if (flow_op.valid && flow_op.code == select_low_bank_op) begin
            bank_ff_q <= 1'b0;
         end
         if (op_intr) begin
            in_isr_q <= 1'b1;
         end else if (flow_op.valid && flow_op.code == return_restore_op) begin
            in_isr_q <= 1'b0;
         end
      end
   end

   // Full twelve bits saved so a return crosses back over the bank boundary
   always_ff @(posedge mclk) begin
      if (op_push) begin
         stack_q[sp_q] <= pc_q;
      end
   end

   // ----------------------------------------
   // Single step
   // ----------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         halted_q <= 1'b0;
      end else if (instr_end && !ss_s2_q) begin
         halted_q <= 1'b1;
      end else if (cyc_start && ss_s2_q) begin
         halted_q <= 1'b0;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   wire is_fx = cur_cycle == cy_fetch_ext;
   wire is_rd = cur_cycle == cy_data_rd;
   wire is_wr = cur_cycle == cy_data_wr;
   wire halt_show = halted_q && cur_cycle == cy_idle;
   wire addr_out = (is_fx || is_rd || is_wr) && s1;
   wire [7:0] cur_addr = is_fx ? cur_faddr[7:0] : cur_daddr;
   wire [7:0] bus_d = read_mode_q ? rom_data :
                      addr_out ? cur_addr :
                      is_wr ? wd_q :
                      (halt_show && s1) ? bus_port_val : pc_q[7:0];
   wire bus_drive = read_mode_q || addr_out || is_wr || halt_show;
   wire [3:0] p2_d = (is_fx && !s1) ? cur_faddr[11:8] :
                     (halt_show && !s1) ? pc_q[11:8] : port2_val;
   bus_pins_type pins_d, pins_q;

   assign pins_d.data_out = bus_d;
   assign pins_d.data_oe_n = !bus_drive;
   assign pins_d.port2_low = p2_d;
   assign pins_d.ale = s1 && booted_q && !read_mode_q;
   assign pins_d.program_store_strobe_n = !(is_fx && program_store_strobe_n_ph);
   assign pins_d.rd_n = !(is_rd && strobe_ph);
   assign pins_d.wr_n = !(is_wr && strobe_ph);

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pins_q <= '{data_out: 8'h00, data_oe_n: 1'b1, port2_low: 4'h0, ale: 1'b0,
                     program_store_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1};
      end else begin
         pins_q <= pins_d;
      end
   end

   // ----------------------------------------
   // Core answers
   // ----------------------------------------
   logic [7:0] instr_q, read_data_q;
   logic instr_valid_q, data_done_q;
   logic [11:0] rom_addr_q;
   wire fetch_end = cyc_end && (cycle_q == cy_fetch_int || cycle_q == cy_fetch_ext);

   // Samples taken as the strobes end; the synchroniser still holds the strobed value
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         instr_q <= 8'h00;
         instr_valid_q <= 1'b0;
         read_data_q <= 8'h00;
         data_done_q <= 1'b0;
         rom_addr_q <= 12'h000;
      end else begin
         instr_valid_q <= fetch_end;
         data_done_q <= cyc_end && (cycle_q == cy_data_rd || cycle_q == cy_data_wr);
         rom_addr_q <= read_mode_q ? rd_addr_q : cur_faddr;
         if (fetch_end) begin
            instr_q <= cycle_q == cy_fetch_ext ? bus_s2_q : rom_data;
         end
         if (cyc_end && cycle_q == cy_data_rd) begin
            read_data_q <= bus_s2_q;
         end
      end
   end

   assign pins = pins_q;
   assign instr = instr_q;
   assign instr_valid = instr_valid_q;
   assign read_data = read_data_q;
   assign data_done = data_done_q;
   assign halted = halted_q;
   assign read_mode = read_mode_q;
   assign rom_addr = rom_addr_q;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_int_quiet;
      @(posedge mclk) disable iff (!rst_n)
      (cycle_q == cy_fetch_int && !tick) |=> pins_q.program_store_strobe_n && pins_q.data_oe_n && pins_q.rd_n;
   endproperty
   a_int_quiet: assert property (p_int_quiet) else $error("internal fetch disturbed the bus");

   property p_high_ext;
      @(posedge mclk) disable iff (!rst_n)
      (cyc_start && !halted_q && !data_req.req && fetch_req && pc_q >= 12'h400) |=> cycle_q == cy_fetch_ext;
   endproperty
   a_high_ext: assert property (p_high_ext) else $error("fetch above limit not external");

   property p_ext_addr;
      @(posedge mclk) disable iff (!rst_n)
      (cycle_q == cy_fetch_ext && s1 && !tick) |=> pins_q.data_out == fa_q[7:0] && !pins_q.data_oe_n && pins_q.ale;
   endproperty
   a_ext_addr: assert property (p_ext_addr) else $error("fetch address missing in address phase");

   property p_program_store_strobe_n_only_fetch;
      @(posedge mclk) disable iff (!rst_n)
      $fell(pins_q.program_store_strobe_n) |-> $past(cycle_q) == cy_fetch_ext && pins_q.data_oe_n;
   endproperty
   a_program_store_strobe_n_only_fetch: assert property (p_program_store_strobe_n_only_fetch) else $error("program strobe outside fetch");

   property p_forced_ext;
      @(posedge mclk) disable iff (!rst_n)
      (cyc_start && ext_mode_q && fetch_req && !halted_q && !data_req.req) |=> cycle_q == cy_fetch_ext;
   endproperty
   a_forced_ext: assert property (p_forced_ext) else $error("forced external fetch went internal");

   property p_bit11_hold;
      @(posedge mclk) disable iff (!rst_n)
      (fetch_start && !flow_op.valid) |=> pc_q[11] == $past(pc_q[11]) && pc_q[10:0] == $past(pc_q[10:0]) + 11'h001;
   endproperty
   a_bit11_hold: assert property (p_bit11_hold) else $error("increment changed bank bit");

   property p_ret_keeps_flop;
      @(posedge mclk) disable iff (!rst_n)
      op_return |=> bank_ff_q == $past(bank_ff_q);
   endproperty
   a_ret_keeps_flop: assert property (p_ret_keeps_flop) else $error("return altered bank flop");

   property p_intr_vector;
      @(posedge mclk) disable iff (!rst_n)
      op_intr |=> in_isr_q && pc_q == {1'b0, ($past(flow_op.vec_high) ? 11'h007 : 11'h003)};
   endproperty
   a_intr_vector: assert property (p_intr_vector) else $error("interrupt vector wrong");

   property p_wr_hold;
      @(posedge mclk) disable iff (!rst_n)
      $rose(pins_q.wr_n) |-> !pins_q.data_oe_n && pins_q.data_out == $past(pins_q.data_out, 2);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write data moved at strobe end");

   property p_halt_addr;
      @(posedge mclk) disable iff (!rst_n)
      (halted_q && cycle_q == cy_idle && phase == ph_s3 && !tick) |=>
         pins_q.data_out == pc_q[7:0] && pins_q.port2_low == pc_q[11:8];
   endproperty
   a_halt_addr: assert property (p_halt_addr) else $error("halt does not show next address");

endmodule

// [verilog/machine_state_timer.sv]
// Machine cycle state sequencer
`timescale 1ns/1ps
`include "ext_bus_regs.svh"

module machine_state_timer
   import ext_bus_pkg::*;
#(
   parameter int STATE_DIV = `STATE_DIV
)
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // State outputs
   output logic tick,
   output phase_type phase
);

   // ----------------------------------------
   // Divider
   // ----------------------------------------
   logic [15:0] cnt_q;
   logic tick_q;
   phase_type phase_q;
   phase_type phase_d;
   wire wrap = cnt_q == 16'(STATE_DIV - 1);

   always_comb begin
      case (phase_q)
         ph_s1: phase_d = ph_s2;
         ph_s2: phase_d = ph_s3;
         ph_s3: phase_d = ph_s4;
         ph_s4: phase_d = ph_s5;
         ph_s5: phase_d = ph_s1;
         default: phase_d = ph_s1;
      endcase
   end

   // Tick marks the first clock of each new state
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
         phase_q <= ph_s5;
      end else begin
         cnt_q <= wrap ? 16'h0000 : cnt_q + 16'h0001;
         tick_q <= wrap;
         if (wrap) begin
            phase_q <= phase_d;
         end
      end
   end

   assign tick = tick_q;
   assign phase = phase_q;

endmodule
